// ### common/semc_map.svh
// constants for the single-wire eeprom function-command handler
`ifndef SEMC_MAP_SVH
`define SEMC_MAP_SVH

// function command codes
`define SEMC_CMD_CLR_OD    8'h8d
`define SEMC_CMD_SET_OD    8'h8b
`define SEMC_CMD_READ_MEM  8'hf0
`define SEMC_CMD_READ_PCRC 8'hc3
`define SEMC_CMD_READ_ALL  8'h65
`define SEMC_CMD_SP_WR     8'h6c
`define SEMC_CMD_SP_RD     8'h69
`define SEMC_CMD_SP_COPY   8'h48

// data field layout
`define SEMC_MEM_BYTES     160
`define SEMC_RSVD_BASE     16'h00a0
`define SEMC_LEGACY_MASK   16'h007f
`define SEMC_LEGACY_END    16'h0080
`define SEMC_PAGE_MASK     16'h001f
`define SEMC_COPY_ALIGN    16'hfff8
`define SEMC_SP_BYTES      8
`define SEMC_SP_OVER       4'h8
`define SEMC_FILL          8'hff
`define SEMC_BIT_LAST      3'h7

// crc polynomial x^8+x^5+x^4+1, reflected for lsb-first shifting
`define SEMC_CRC_POLY      8'h8c

// timing: core clock and nonvolatile programming delay
`define SEMC_CLK_PERIOD_NS 100
`define SEMC_NVM_PROG_NS   10000000
`define SEMC_BUSY_W        24

`endif

// ### common/semc_pkg.sv
// types shared by the eeprom command handler
`include "semc_map.svh"

package semc_pkg;

    // one-hot sequence states
    typedef enum logic [8:0] {
        S_IDLE    = 9'h001,
        S_ADDR    = 9'h002,
        S_HDR_CRC = 9'h004,
        S_RD_DATA = 9'h008,
        S_RD_CRC  = 9'h010,
        S_ONES    = 9'h020,
        S_SP_WR   = 9'h040,
        S_SP_RD   = 9'h080,
        S_DONE    = 9'h100
    } semc_state_t;

    // time-slot events from the bus physical layer
    typedef struct packed {
        logic wr_stb;
        logic wr_bit;
        logic rd_stb;
        logic bus_rst;
    } semc_slot_t;

    // whole state of the command handler
    typedef struct packed {
        semc_state_t                     state;
        logic [7:0]                      cmd;
        logic [7:0]                      rx;
        logic [7:0]                      tx;
        logic [2:0]                      cnt;
        logic                            nb;
        logic [15:0]                     addr;
        logic [7:0]                      crc;
        logic [3:0]                      idx;
        logic                            od;
        logic [`SEMC_BUSY_W-1:0]         busy;
        logic [`SEMC_SP_BYTES-1:0][7:0]  sp;
        logic [`SEMC_MEM_BYTES-1:0][7:0] mem;
    } semc_st_t;

    // power-up state: blank memory reads ones, standard speed
    localparam semc_st_t SEMC_ST_RST = '{
        state: S_IDLE,
        cmd:   8'h00,
        rx:    8'h00,
        tx:    `SEMC_FILL,
        cnt:   3'h0,
        nb:    1'b0,
        addr:  16'h0000,
        crc:   8'h00,
        idx:   4'h0,
        od:    1'b0,
        busy:  '0,
        sp:    '0,
        mem:   '1
    };

    function automatic logic semc_legacy(input logic [7:0] cmd);
        return (cmd == `SEMC_CMD_READ_MEM) || (cmd == `SEMC_CMD_READ_PCRC);
    endfunction : semc_legacy

    function automatic logic semc_in_field(input logic [15:0] addr);
        return addr < `SEMC_RSVD_BASE;
    endfunction : semc_in_field

endpackage : semc_pkg

// ### design/semc_cmds.sv
// function-command handler: speed, memory reads, scratchpad
`timescale 1ns/1ps
`default_nettype none
`include "semc_map.svh"

module semc_cmds #(
    parameter int unsigned P_NVM_PROG_CYCLES =
        (`SEMC_NVM_PROG_NS + `SEMC_CLK_PERIOD_NS - 1) / `SEMC_CLK_PERIOD_NS
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rstn,
    input  wire semc_pkg::semc_slot_t i_slot,
    output logic                      o_rd_bit,
    output logic                      o_overdrive,
    output logic                      o_nvm_busy
);
    import semc_pkg::*;

    // full mask as a vector so its two bytes can be taken apart
    localparam logic [15:0] LEGACY_MASK = `SEMC_LEGACY_MASK;

    semc_st_t    s_q;
    semc_st_t    s_d;
    logic [7:0]  rx_byte;
    logic        rx_done;
    logic        tx_done;
    logic        legacy;
    logic [7:0]  rd_byte;
    logic [7:0]  hdr_byte;
    logic [7:0]  crc_seed;
    logic [7:0]  crc_data;
    logic [7:0]  crc_out;
    logic [15:0] full_addr;
    logic [15:0] copy_base;
    logic        page_end;

    // incoming bits shift in lsb first; a byte counts only when whole
    assign rx_byte   = {i_slot.wr_bit, s_q.rx[7:1]};
    assign rx_done   = i_slot.wr_stb && (s_q.cnt == `SEMC_BIT_LAST);
    assign tx_done   = i_slot.rd_stb && (s_q.cnt == `SEMC_BIT_LAST);
    assign legacy    = semc_legacy(s_q.cmd);
    assign full_addr = {rx_byte, s_q.addr[7:0]};
    assign copy_base = full_addr & `SEMC_COPY_ALIGN;

    // next data byte; reserved space reads as ones
    assign rd_byte = semc_in_field(s_q.addr) ? s_q.mem[s_q.addr[7:0]]
                                             : `SEMC_FILL;

    // legacy commands fold the address before it enters the crc
    always_comb begin
        hdr_byte = rx_byte;
        if (s_q.state == S_ADDR && legacy) begin
            hdr_byte = s_q.nb ? (rx_byte & LEGACY_MASK[15:8])
                              : (rx_byte & LEGACY_MASK[7:0]);
        end
    end

    // crc feed: header bytes while receiving, data bytes while sending
    always_comb begin
        crc_seed = s_q.crc;
        crc_data = rd_byte;
        if (s_q.state == S_IDLE) begin
            crc_seed = 8'h00;
            crc_data = hdr_byte;
        end else if (s_q.state == S_ADDR) begin
            crc_data = hdr_byte;
        end else if (s_q.state == S_HDR_CRC || s_q.state == S_RD_CRC) begin
            crc_seed = 8'h00;
        end
    end

    semc_crc8 u_crc (
        .i_crc  (crc_seed),
        .i_data (crc_data),
        .o_crc  (crc_out)
    );

    // end of the current read run, address already past the last byte
    always_comb begin
        if (legacy) begin
            page_end = (s_q.addr == `SEMC_LEGACY_END) ||
                       (s_q.cmd == `SEMC_CMD_READ_PCRC &&
                        (s_q.addr & `SEMC_PAGE_MASK) == 16'h0000);
        end else begin
            page_end = (s_q.addr == `SEMC_RSVD_BASE);
        end
    end

    // sequence engine
    always_comb begin
        s_d = s_q;
        if (s_q.busy != '0) begin
            s_d.busy = s_q.busy - `SEMC_BUSY_W'(1);
        end
        if (i_slot.bus_rst) begin
            // only sequence state clears; memory, scratchpad, speed stay
            s_d.state = S_IDLE;
            s_d.cnt   = 3'h0;
            s_d.nb    = 1'b0;
            s_d.tx    = `SEMC_FILL;
        end else begin
            // bit shifting common to receive and send states
            if ((s_q.state == S_IDLE || s_q.state == S_ADDR ||
                 s_q.state == S_SP_WR) && i_slot.wr_stb) begin
                s_d.rx  = rx_byte;
                s_d.cnt = s_q.cnt + 3'h1;
            end
            if ((s_q.state == S_HDR_CRC || s_q.state == S_RD_DATA ||
                 s_q.state == S_RD_CRC || s_q.state == S_ONES ||
                 s_q.state == S_SP_RD) && i_slot.rd_stb) begin
                s_d.tx  = {1'b1, s_q.tx[7:1]};
                s_d.cnt = s_q.cnt + 3'h1;
            end
            case (s_q.state)
                S_IDLE: begin
                    if (rx_done) begin
                        s_d.cmd = rx_byte;
                        s_d.crc = crc_out;
                        s_d.nb  = 1'b0;
                        case (rx_byte)
                            `SEMC_CMD_CLR_OD: begin
                                s_d.od    = 1'b0;
                                s_d.busy  = `SEMC_BUSY_W'(P_NVM_PROG_CYCLES);
                                s_d.state = S_DONE;
                            end
                            `SEMC_CMD_SET_OD: begin
                                s_d.od    = 1'b1;
                                s_d.busy  = `SEMC_BUSY_W'(P_NVM_PROG_CYCLES);
                                s_d.state = S_DONE;
                            end
                            `SEMC_CMD_READ_MEM, `SEMC_CMD_READ_PCRC,
                            `SEMC_CMD_READ_ALL, `SEMC_CMD_SP_COPY,
                            `SEMC_CMD_SP_WR, `SEMC_CMD_SP_RD: begin
                                s_d.state = S_ADDR;
                            end
                            default: begin
                                s_d.state = S_DONE;
                            end
                        endcase
                    end
                end
                S_ADDR: begin
                    if (rx_done && (s_q.cmd == `SEMC_CMD_SP_WR ||
                                    s_q.cmd == `SEMC_CMD_SP_RD)) begin
                        // start index; anything above 7 disables the run
                        s_d.idx = (rx_byte < 8'(`SEMC_SP_BYTES)) ?
                                  rx_byte[3:0] : `SEMC_SP_OVER;
                        s_d.state = (s_q.cmd == `SEMC_CMD_SP_WR) ?
                                    S_SP_WR : S_SP_RD;
                        if (s_q.cmd == `SEMC_CMD_SP_RD) begin
                            if (rx_byte < 8'(`SEMC_SP_BYTES)) begin
                                s_d.tx  = s_q.sp[rx_byte[2:0]];
                                s_d.idx = rx_byte[3:0] + 4'h1;
                            end else begin
                                s_d.tx = `SEMC_FILL;
                            end
                        end
                    end else if (rx_done && !s_q.nb) begin
                        s_d.addr[7:0] = rx_byte; // target_addr_low
                        s_d.crc       = crc_out;
                        s_d.nb        = 1'b1;
                    end else if (rx_done) begin
                        s_d.crc = crc_out;
                        if (s_q.cmd == `SEMC_CMD_SP_COPY) begin
                            // reserved targets are dropped silently
                            if (semc_in_field(copy_base)) begin
                                for (int k = 0; k < `SEMC_SP_BYTES; k++) begin
                                    s_d.mem[copy_base[7:0] | 8'(k)] =
                                        s_q.sp[k];
                                end
                                s_d.busy = `SEMC_BUSY_W'(P_NVM_PROG_CYCLES);
                            end
                            s_d.state = S_DONE;
                        end else begin
                            s_d.addr = legacy ?
                                (full_addr & `SEMC_LEGACY_MASK) :
                                full_addr;
                            s_d.tx    = crc_out;
                            s_d.state = S_HDR_CRC;
                        end
                    end
                end
                S_HDR_CRC: begin
                    if (tx_done) begin
                        if (!semc_in_field(s_q.addr)) begin
                            s_d.tx    = `SEMC_FILL;
                            s_d.state = S_ONES;
                        end else begin
                            s_d.tx    = rd_byte;
                            s_d.crc   = crc_out;
                            s_d.addr  = s_q.addr + 16'h0001;
                            s_d.state = S_RD_DATA;
                        end
                    end
                end
                S_RD_DATA: begin
                    if (tx_done && page_end) begin
                        s_d.tx    = s_q.crc;
                        s_d.state = S_RD_CRC;
                    end else if (tx_done) begin
                        s_d.tx   = rd_byte;
                        s_d.crc  = crc_out;
                        s_d.addr = s_q.addr + 16'h0001;
                    end
                end
                S_RD_CRC: begin
                    // page-crc read continues into the next page up to page 3
                    if (tx_done && s_q.cmd == `SEMC_CMD_READ_PCRC &&
                        s_q.addr != `SEMC_LEGACY_END) begin
                        s_d.tx    = rd_byte;
                        s_d.crc   = crc_out;
                        s_d.addr  = s_q.addr + 16'h0001;
                        s_d.state = S_RD_DATA;
                    end else if (tx_done) begin
                        s_d.tx    = `SEMC_FILL;
                        s_d.state = S_ONES;
                    end
                end
                S_ONES: begin
                    s_d.tx = `SEMC_FILL;
                end
                S_SP_WR: begin
                    // only whole bytes land; others keep old contents
                    if (rx_done && s_q.idx < `SEMC_SP_OVER) begin
                        s_d.sp[s_q.idx[2:0]] = rx_byte;
                        s_d.idx = s_q.idx + 4'h1;
                    end
                end
                S_SP_RD: begin
                    if (tx_done && s_q.idx < `SEMC_SP_OVER) begin
                        s_d.tx  = s_q.sp[s_q.idx[2:0]];
                        s_d.idx = s_q.idx + 4'h1;
                    end else if (tx_done) begin
                        s_d.tx = `SEMC_FILL;
                    end
                end
                S_DONE: begin
                    s_d.tx = `SEMC_FILL;
                end
                default: begin
                    s_d.state = S_IDLE;
                end
            endcase
        end
    end

    // state register; async reset is the power-up value
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= SEMC_ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state
    assign o_rd_bit    = s_q.tx[0];
    assign o_overdrive = s_q.od;
    assign o_nvm_busy  = (s_q.busy != '0);

    // checks
    property p_set_od;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_IDLE && rx_done && !i_slot.bus_rst &&
         rx_byte == `SEMC_CMD_SET_OD) |=> (o_overdrive && o_nvm_busy);
    endproperty
    a_set_od: assert property (p_set_od)
        else $error("set overdrive not applied");

    property p_clr_od;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_IDLE && rx_done && !i_slot.bus_rst &&
         rx_byte == `SEMC_CMD_CLR_OD) |=> (!o_overdrive && o_nvm_busy)
        ##1 !o_overdrive;
    endproperty
    a_clr_od: assert property (p_clr_od)
        else $error("clear overdrive not applied");

    property p_bus_rst_keep;
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_slot.bus_rst |=> (s_q.state == S_IDLE && $stable(s_q.sp) &&
                            $stable(o_overdrive));
    endproperty
    a_bus_rst_keep: assert property (p_bus_rst_keep)
        else $error("bus reset disturbed kept state");

    property p_ones;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_ONES) |-> o_rd_bit;
    endproperty
    a_ones: assert property (p_ones)
        else $error("ones state sent a zero");

    property p_sp_over;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_SP_WR && rx_done && !i_slot.bus_rst &&
         s_q.idx == `SEMC_SP_OVER) |=> $stable(s_q.sp);
    endproperty
    a_sp_over: assert property (p_sp_over)
        else $error("scratchpad written past last index");

    property p_legacy_fold;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_RD_DATA && legacy) |-> s_q.addr <= `SEMC_LEGACY_END;
    endproperty
    a_legacy_fold: assert property (p_legacy_fold)
        else $error("legacy read left pages 0 to 3");

    property p_all_crc;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_RD_DATA && !legacy && tx_done && !i_slot.bus_rst &&
         s_q.addr == `SEMC_RSVD_BASE) |=>
        (s_q.state == S_RD_CRC && s_q.tx == $past(s_q.crc));
    endproperty
    a_all_crc: assert property (p_all_crc)
        else $error("read-all closing crc missing");

    property p_copy;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_ADDR && s_q.cmd == `SEMC_CMD_SP_COPY && rx_done &&
         s_q.nb && !i_slot.bus_rst && semc_in_field(copy_base)) |=>
        (s_q.mem[$past(copy_base[7:0])] == $past(s_q.sp[0]) &&
         s_q.state == S_DONE);
    endproperty
    a_copy: assert property (p_copy)
        else $error("copy did not program aligned block");

    property p_sp_rd_ones;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_SP_RD && tx_done && !i_slot.bus_rst &&
         s_q.idx == `SEMC_SP_OVER) |=> (s_q.tx == `SEMC_FILL);
    endproperty
    a_sp_rd_ones: assert property (p_sp_rd_ones)
        else $error("scratchpad read past index not ones");

    property p_page_crc;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s_q.state == S_RD_DATA && s_q.cmd == `SEMC_CMD_READ_PCRC &&
         tx_done && !i_slot.bus_rst &&
         (s_q.addr & `SEMC_PAGE_MASK) == 16'h0000) |=> s_q.state == S_RD_CRC;
    endproperty
    a_page_crc: assert property (p_page_crc)
        else $error("page crc not inserted");

endmodule : semc_cmds
`default_nettype wire

// ### design/semc_crc8.sv
// one-byte step of the lsb-first 8-bit bus crc
`timescale 1ns/1ps
`default_nettype none
`include "semc_map.svh"

module semc_crc8 (
    input  wire logic [7:0] i_crc,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_crc
);

    // eight serial steps folded into one cycle
    always_comb begin
        logic [7:0] c;
        logic       fb;
        c  = i_crc;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ i_data[i];
            c  = c >> 1;
            if (fb) begin
                c = c ^ `SEMC_CRC_POLY;
            end
        end
        o_crc = c;
    end

endmodule : semc_crc8
`default_nettype wire

// ### dv/semc_host_model.sv
// bus master model that issues time slots and reset pulses
`timescale 1ns/1ps
`default_nettype none

module semc_host_model (
    input  wire logic                i_core_clk,
    input  wire logic                i_rd_bit,
    output var semc_pkg::semc_slot_t o_slot
);
    import semc_pkg::*;

    initial o_slot = '0;

    // one slot over two edges; wr_bit turned round afterwards so a stale
    // value is never mistaken for a driven one
    task automatic slot(input logic w, input logic b, output logic r);
        @(posedge i_core_clk);
        o_slot <= '{wr_stb: w, wr_bit: b, rd_stb: ~w, bus_rst: 1'b0};
        @(posedge i_core_clk);
        r = i_rd_bit;
        o_slot <= '{wr_stb: 1'b0, wr_bit: ~b, rd_stb: 1'b0, bus_rst: 1'b0};
    endtask : slot

    // reset pulse, also the retry path after a bad crc or unfit scratchpad
    task automatic bus_reset();
        @(posedge i_core_clk);
        o_slot.bus_rst <= 1'b1;
        @(posedge i_core_clk);
        o_slot.bus_rst <= 1'b0;
    endtask : bus_reset

    // bytes go out lsb first
    task automatic wr_byte(input logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++) slot(1'b1, b[i], r);
        @(posedge i_core_clk);
    endtask : wr_byte

    task automatic rd_byte(output logic [7:0] b);
        for (int i = 0; i < 8; i++) slot(1'b0, 1'b0, b[i]);
        @(posedge i_core_clk);
    endtask : rd_byte
endmodule : semc_host_model
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the eeprom command handler
`timescale 1ns/1ps
`default_nettype none

module tb;
    import semc_pkg::*;
    logic       i_core_clk, i_rstn, rd_bit, od, busy, r;
    semc_slot_t slot;
    logic [7:0] exp_mem [160];
    logic [7:0] exp_sp [8];
    int         error_cnt = 0;
    int         checks_done = 0;

    semc_cmds #(.P_NVM_PROG_CYCLES(20)) uut (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_slot(slot),
        .o_rd_bit(rd_bit), .o_overdrive(od), .o_nvm_busy(busy));
    semc_host_model host (
        .i_core_clk(i_core_clk), .i_rd_bit(rd_bit), .o_slot(slot));

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    // reference crc, lsb first, reflected x^8+x^5+x^4+1
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
        end
        return c;
    endfunction : crc8

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rd_chk(input string n, input logic [7:0] e);
        logic [7:0] b;
        host.rd_byte(b);
        chk(n, e, b);
    endtask : rd_chk

    // bus reset, then a command and up to two argument bytes
    task automatic issue(input int n, input logic [7:0] b0, b1, b2);
        host.bus_reset();
        host.wr_byte(b0);
        if (n > 1) host.wr_byte(b1);
        if (n > 2) host.wr_byte(b2);
    endtask : issue

    // mlo/mhi are the address bytes the device should fold into the crc
    task automatic hdr(input logic [7:0] c, lo, hi, mlo, mhi);
        logic [7:0] e;
        e = crc8(crc8(crc8(8'h00, c), mlo), mhi);
        issue(3, c, lo, hi);
        rd_chk("header crc", e);
    endtask : hdr

    task automatic run(input int first, input int last);
        logic [7:0] c;
        c = 8'h00;
        for (int a = first; a <= last; a++) begin
            rd_chk("data", exp_mem[a]);
            c = crc8(c, exp_mem[a]);
        end
        rd_chk("data crc", c);
    endtask : run

    // bounded wait for the programming delay to expire
    task automatic wait_idle();
        for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge i_core_clk);
        chk("nvm busy idle", 8'h00, {7'h0, busy});
    endtask : wait_idle

    task automatic t_speed();
        issue(1, 8'h8b, 8'h00, 8'h00);
        chk("overdrive set", 8'h01, {7'h0, od});
        chk("nvm busy", 8'h01, {7'h0, busy});
        wait_idle();
        host.bus_reset();
        chk("overdrive kept", 8'h01, {7'h0, od});
        issue(1, 8'h8d, 8'h00, 8'h00);
        chk("overdrive clear", 8'h00, {7'h0, od});
        chk("clear busy", 8'h01, {7'h0, busy});
        wait_idle();
    endtask : t_speed

    task automatic t_sp_wr();
        logic [7:0] d;
        issue(2, 8'h6c, 8'h06, 8'h00);
        // three bytes from index 6; the third falls past the end
        for (int i = 0; i < 3; i++) begin
            d = 8'haa + 8'h11 * 8'(i);
            host.wr_byte(d);
        end
        exp_sp[6] = 8'haa;
        exp_sp[7] = 8'hbb;
        // half a byte then reset must leave sp[0] alone
        issue(2, 8'h6c, 8'h00, 8'h00);
        d = 8'h0f;
        for (int i = 0; i < 4; i++) host.slot(1'b1, d[i], r);
        t_sp_rd();
    endtask : t_sp_wr

    task automatic t_sp_rd();
        issue(2, 8'h69, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) rd_chk("scratch", exp_sp[i]);
        rd_chk("scratch ones", 8'hff);
        issue(2, 8'h69, 8'h09, 8'h00);
        rd_chk("scratch index over", 8'hff);
    endtask : t_sp_rd

    task automatic t_copy();
        issue(3, 8'h48, 8'h27, 8'h00);
        for (int i = 0; i < 8; i++) exp_mem[32 + i] = exp_sp[i];
        chk("copy busy", 8'h01, {7'h0, busy});
        wait_idle();
        hdr(8'h65, 8'h20, 8'h00, 8'h20, 8'h00);
        run(32, 159);
        rd_chk("read-all ones", 8'hff);
        hdr(8'h65, 8'ha0, 8'h00, 8'ha0, 8'h00);
        rd_chk("reserved ones", 8'hff);
    endtask : t_copy

    task automatic t_legacy();
        hdr(8'hf0, 8'he0, 8'h01, 8'h60, 8'h00);
        run(96, 127);
        rd_chk("legacy ones", 8'hff);
        hdr(8'hf0, 8'h25, 8'h00, 8'h25, 8'h00);
        rd_chk("legacy data", exp_mem[37]);
        host.bus_reset();
        rd_chk("no crc after reset", 8'hff);
        hdr(8'hc3, 8'h24, 8'h00, 8'h24, 8'h00);
        run(36, 63);
        run(64, 95);
        rd_chk("page data", exp_mem[96]);
        t_sp_rd();
        hdr(8'hc3, 8'h7c, 8'h00, 8'h7c, 8'h00);
        run(124, 127);
        rd_chk("page ones", 8'hff);
    endtask : t_legacy

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // watchdog: whole run needs well under 20000 cycles
    initial begin
        #5000000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        foreach (exp_mem[i]) exp_mem[i] = 8'hff;
        foreach (exp_sp[i]) exp_sp[i] = 8'h00;
        i_rstn = 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        chk("reset overdrive", 8'h00, {7'h0, od});
        chk("reset busy", 8'h00, {7'h0, busy});
        chk("reset rd bit", 8'h01, {7'h0, rd_bit});
        t_speed();
        t_sp_wr();
        t_sp_rd();
        t_copy();
        t_legacy();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
